/* imdr_pkg.sv */
package imdr_pkg;

  // ****************************************************************
  // Record layout
  // ****************************************************************
  localparam int RECORD_BYTES = 20;
  localparam logic [4:0] OFS_FAULT_SUMMARY = 5'h00;
  localparam logic [4:0] OFS_CLASS_INFO    = 5'h01;
  localparam logic [4:0] OFS_SPARE         = 5'h02;
  localparam logic [4:0] OFS_INTERNAL      = 5'h03;
  localparam logic [4:0] OFS_CHANNEL_KIND  = 5'h04;
  localparam logic [4:0] OFS_DIAG_BITS     = 5'h05;
  localparam logic [4:0] OFS_CHANNEL_COUNT = 5'h06;
  localparam logic [4:0] OFS_LOST_EDGE     = 5'h07;
  localparam logic [4:0] OFS_CHAN_FAULT_LO = 5'h08;
  localparam logic [4:0] OFS_CHAN_FAULT_HI = 5'h0f;
  localparam logic [4:0] OFS_TIMESTAMP     = 5'h10;

  // ****************************************************************
  // Field positions and fixed values
  // ****************************************************************
  localparam int BIT_MODULE_FAIL   = 0;
  localparam int BIT_EXTERNAL_ERR  = 2;
  localparam int BIT_CHANNEL_ERR   = 3;
  localparam int BIT_BUF_OVERFLOW  = 3;
  localparam int BIT_IRQ_LOST      = 6;
  localparam int BIT_CHAN_INFO     = 4;
  localparam logic [3:0] CLASS_DIGITAL     = 4'hf;
  localparam logic [6:0] KIND_DIGITAL_IN   = 7'h70;
  localparam logic [7:0] DIAG_BITS_VALUE   = 8'h00;
  localparam logic [7:0] CHANNEL_COUNT_VAL = 8'h04;
  localparam logic [7:0] IRQ_ENABLE_ON     = 8'h40;
  localparam logic [7:0] IRQ_ENABLE_OFF    = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_MHZ    = 100;
  localparam int TICK_US      = 1;
  localparam int TICK_CYCLES  = TICK_US * CLOCK_MHZ;

  // Fault causes presented by the module's own logic.
  typedef struct packed {
    logic       module_fail;
    logic       external_err;
    logic       buf_overflow;
    logic       irq_lost;
    logic [3:0] edge_lost;
  } imdr_cause_type;

endpackage

/* imdr_ticker.sv */
`timescale 1ns/10ps
module imdr_ticker
#(
  parameter int PRESCALE = imdr_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Count
  output logic [31:0]      us_count
);

  logic [6:0]  pre_reg;
  logic [6:0]  pre_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  always_comb
  begin
    pre_next = pre_reg + 7'h01;
    cnt_next = cnt_reg;
    if (pre_reg == 7'(PRESCALE - 1))
    begin
      pre_next = 7'h00;
      // Natural 32-bit overflow gives the wrap to zero.
      cnt_next = cnt_reg + 32'h00000001; // R19 R13
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pre_reg <= 7'h00;
      cnt_reg <= 32'h00000000; // R12
    end
    else
    begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
    end
  end

  assign us_count = cnt_reg;

  a_tick_spacing: assert property ( // R19
    @(posedge mclk) disable iff (!reset_n)
    (pre_reg != 7'(PRESCALE - 1)) |=> (cnt_reg == $past(cnt_reg)))
    else $error("ticker moved off its prescaler boundary");

  a_tick_step: assert property ( // R13 R19
    @(posedge mclk) disable iff (!reset_n)
    (pre_reg == 7'(PRESCALE - 1)) |=> (cnt_reg == $past(cnt_reg) + 1))
    else $error("ticker did not advance by one");

endmodule

/* imdr_sync.sv */
`timescale 1ns/10ps
module imdr_sync
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  // A bit changes only once stages two and three agree.
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end
    else
    begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule

/* imdr_diag_record.sv */
// What this block does
// [R1] Fault summary bit 0 set on module failure.
// [R2] Summary bit 2 external error, bit 3 channel error, others reserved.
// [R3] Module class nibble reads 1111b, meaning digital module.
// [R4] Class bit 4 flags channel information present; bits 7..5 reserved.
// [R5] Internal fault bit 3 set on diagnostics buffer overflow.
// [R6] Internal fault bit 6 set on lost process interrupt; rest reserved.
// [R7] Channel kind reads 70h, digital input; bit 7 reserved.
// [R8] Diagnostic bits per channel reads constant 00h.
// [R9] Channel count reads constant 04h.
// [R10] Lost-edge bits 0..3 follow channels 0..3; upper nibble reserved.
// [R11] Timestamp holds ticker value captured at the diagnostic event.
// [R12] A 32-bit microsecond ticker starts at zero after power-on.
// [R13] Ticker wraps to zero after its maximum and keeps counting.
// [R14] Outgoing diagnostic interrupt raised automatically when causes vanish.
// [R15] Channel events between incoming and outgoing interrupt are discarded.
// [R16] Red fault indicator lit from first incoming to last outgoing.
// [R17] Host writes 40h to enable diagnostic interrupts, 00h to disable.
// [R18] Reserved bits and bytes read as zero.
// [R19] Ticker advances once per microsecond through a fixed prescaler.
`timescale 1ns/10ps
module imdr_diag_record
#(
  parameter int CHANNELS = 4
)
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // Fault causes from module logic, same clock
  input  wire imdr_pkg::imdr_cause_type cause,
  // Physical input lines, asynchronous
  input  wire logic [CHANNELS-1:0]   input_line,
  // Diagnostic enable parameter byte
  input  wire logic [7:0]            diag_irq_enable,
  // Record read port
  input  wire logic                  rd_en,
  input  wire logic [4:0]            rd_addr,
  output logic [7:0]                 rd_data,
  // Interrupt events to the coupler
  output logic                       diag_incoming,
  output logic                       diag_outgoing,
  // Indicators
  output logic                       fault_indicator,
  output logic [CHANNELS-1:0]        input_state
);

  // ****************************************************************
  // Input synchronisers and ticker
  // ****************************************************************
  logic [CHANNELS-1:0] line_sync;
  logic [31:0]         us_now;

  imdr_sync #(.WIDTH(CHANNELS)) u_sync
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in (input_line),
    .sync_out (line_sync)
  );

  imdr_ticker u_ticker
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .us_count (us_now)
  );

  // ****************************************************************
  // Diagnostic state
  // ****************************************************************
  typedef enum logic [1:0]
  {
    ST_CLEAR  = 2'b01,
    ST_ACTIVE = 2'b10
  } imdr_state_type;

  imdr_state_type      state_reg;
  imdr_state_type      state_next;
  logic [7:0]          summary_reg;
  logic [7:0]          summary_next;
  logic [7:0]          internal_reg;
  logic [7:0]          internal_next;
  logic [7:0]          lost_reg;
  logic [7:0]          lost_next;
  logic [31:0]         stamp_reg;
  logic [31:0]         stamp_next;
  logic                inc_reg;
  logic                inc_next;
  logic                out_reg;
  logic                out_next;
  logic                led_reg;
  logic                led_next;
  logic [7:0]          rdata_reg;
  logic [7:0]          rdata_next;
  logic [CHANNELS-1:0] state_in_reg;
  logic                enabled;
  logic                any_cause;
  logic [7:0]          sum_now;
  logic [7:0]          int_now;
  logic [7:0]          lost_now;

  assign enabled   = (diag_irq_enable == imdr_pkg::IRQ_ENABLE_ON); // R17
  assign any_cause = cause.module_fail | cause.external_err |
                     cause.buf_overflow | cause.irq_lost |
                     (|cause.edge_lost);

  // Live view of the causes in record form; reserved bits stay zero.
  always_comb
  begin
    sum_now  = 8'h00;
    int_now  = 8'h00;
    lost_now = 8'h00;
    sum_now[imdr_pkg::BIT_MODULE_FAIL]  = cause.module_fail; // R1
    sum_now[imdr_pkg::BIT_EXTERNAL_ERR] = cause.external_err; // R2
    sum_now[imdr_pkg::BIT_CHANNEL_ERR]  = |cause.edge_lost; // R2
    int_now[imdr_pkg::BIT_BUF_OVERFLOW] = cause.buf_overflow; // R5
    int_now[imdr_pkg::BIT_IRQ_LOST]     = cause.irq_lost; // R6
    lost_now[3:0] = cause.edge_lost; // R10 R18
  end

  always_comb
  begin
    state_next    = state_reg;
    summary_next  = summary_reg;
    internal_next = internal_reg;
    lost_next     = lost_reg;
    stamp_next    = stamp_reg;
    inc_next      = 1'b0;
    out_next      = 1'b0;
    led_next      = led_reg;
    unique case (state_reg)
      ST_CLEAR:
      begin
        if (enabled && any_cause)
        begin
          state_next    = ST_ACTIVE;
          summary_next  = sum_now;
          internal_next = int_now;
          lost_next     = lost_now;
          stamp_next    = us_now; // R11
          inc_next      = 1'b1;
          led_next      = 1'b1; // R16
        end
      end
      ST_ACTIVE:
      begin
        // Record is frozen here, so later channel events are dropped.
        if (!any_cause || !enabled)
        begin
          state_next = ST_CLEAR; // R15
          out_next   = 1'b1; // R14
          led_next   = 1'b0; // R16
        end
      end
    endcase
  end

  // ****************************************************************
  // Record read port
  // ****************************************************************
  always_comb
  begin
    rdata_next = rdata_reg;
    if (rd_en)
    begin
      rdata_next = 8'h00; // R18
      if (rd_addr == imdr_pkg::OFS_FAULT_SUMMARY)
        rdata_next = summary_reg;
      else if (rd_addr == imdr_pkg::OFS_CLASS_INFO)
        rdata_next = {3'h0, 1'b1, imdr_pkg::CLASS_DIGITAL}; // R3 R4
      else if (rd_addr == imdr_pkg::OFS_INTERNAL)
        rdata_next = internal_reg;
      else if (rd_addr == imdr_pkg::OFS_CHANNEL_KIND)
        rdata_next = {1'b0, imdr_pkg::KIND_DIGITAL_IN}; // R7
      else if (rd_addr == imdr_pkg::OFS_DIAG_BITS)
        rdata_next = imdr_pkg::DIAG_BITS_VALUE; // R8
      else if (rd_addr == imdr_pkg::OFS_CHANNEL_COUNT)
        rdata_next = imdr_pkg::CHANNEL_COUNT_VAL; // R9
      else if (rd_addr == imdr_pkg::OFS_LOST_EDGE)
        rdata_next = lost_reg;
      else if (rd_addr >= imdr_pkg::OFS_TIMESTAMP &&
               rd_addr <= imdr_pkg::OFS_TIMESTAMP + 5'h03)
        rdata_next = stamp_reg[8*(rd_addr[1:0]) +: 8]; // R11
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_reg    <= ST_CLEAR;
      summary_reg  <= 8'h00;
      internal_reg <= 8'h00;
      lost_reg     <= 8'h00;
      stamp_reg    <= 32'h00000000;
      inc_reg      <= 1'b0;
      out_reg      <= 1'b0;
      led_reg      <= 1'b0;
      rdata_reg    <= 8'h00;
      state_in_reg <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      summary_reg  <= summary_next;
      internal_reg <= internal_next;
      lost_reg     <= lost_next;
      stamp_reg    <= stamp_next;
      inc_reg      <= inc_next;
      out_reg      <= out_next;
      led_reg      <= led_next;
      rdata_reg    <= rdata_next;
      state_in_reg <= line_sync;
    end
  end

  assign rd_data         = rdata_reg;
  assign diag_incoming   = inc_reg;
  assign diag_outgoing   = out_reg;
  assign fault_indicator = led_reg;
  assign input_state     = state_in_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_class_byte: assert property ( // R3 R4
    @(posedge mclk) disable iff (!reset_n)
    (rd_en && rd_addr == imdr_pkg::OFS_CLASS_INFO) |=> rd_data == 8'h1f)
    else $error("class byte wrong");

  a_kind_byte: assert property ( // R7
    @(posedge mclk) disable iff (!reset_n)
    (rd_en && rd_addr == imdr_pkg::OFS_CHANNEL_KIND) |=> rd_data == 8'h70)
    else $error("channel kind wrong");

  a_count_byte: assert property ( // R9
    @(posedge mclk) disable iff (!reset_n)
    (rd_en && rd_addr == imdr_pkg::OFS_CHANNEL_COUNT) |=> rd_data == 8'h04)
    else $error("channel count wrong");

  a_bits_byte: assert property ( // R8
    @(posedge mclk) disable iff (!reset_n)
    (rd_en && rd_addr == imdr_pkg::OFS_DIAG_BITS) |=> rd_data == 8'h00)
    else $error("diag bits byte wrong");

  a_spare_zero: assert property ( // R18
    @(posedge mclk) disable iff (!reset_n)
    (rd_en && rd_addr == imdr_pkg::OFS_SPARE) |=> rd_data == 8'h00)
    else $error("spare byte not zero");

  a_reserved_zero: assert property ( // R18
    @(posedge mclk) disable iff (!reset_n)
    (summary_reg & 8'hf2) == 8'h00 && (internal_reg & 8'hb7) == 8'h00 &&
    lost_reg[7:4] == 4'h0)
    else $error("reserved bit set");

  a_summary_bits: assert property ( // R2
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == ST_CLEAR && enabled && any_cause) |=>
    summary_reg[2] == $past(cause.external_err) &&
    summary_reg[3] == $past(|cause.edge_lost))
    else $error("summary bits not captured");

  a_internal_bits: assert property ( // R5 R6
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == ST_CLEAR && enabled && any_cause) |=>
    internal_reg[3] == $past(cause.buf_overflow) &&
    internal_reg[6] == $past(cause.irq_lost))
    else $error("internal fault bits not captured");

  a_lost_bits: assert property ( // R10
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == ST_CLEAR && enabled && any_cause) |=>
    lost_reg[3:0] == $past(cause.edge_lost))
    else $error("lost edge bits not captured");

  a_stamp_capture: assert property ( // R11
    @(posedge mclk) disable iff (!reset_n)
    $rose(inc_reg) |-> stamp_reg == $past(us_now))
    else $error("timestamp not captured at event");

  a_record_frozen: assert property ( // R15
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == ST_ACTIVE && $past(state_reg) == ST_ACTIVE) |->
    $stable(lost_reg))
    else $error("record changed while active");

  a_record_held: assert property ( // R15
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == ST_ACTIVE && $past(state_reg) == ST_ACTIVE) |->
    $stable(summary_reg) && $stable(internal_reg) && $stable(stamp_reg))
    else $error("record bytes changed while active");

  a_outgoing_auto: assert property ( // R14
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == ST_ACTIVE && !any_cause) |=> out_reg && !led_reg)
    else $error("outgoing not raised");

  a_outgoing_off: assert property ( // R14
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == ST_ACTIVE && !enabled) |=> out_reg && !led_reg)
    else $error("outgoing not raised on disable");

  a_led_window: assert property ( // R16
    @(posedge mclk) disable iff (!reset_n)
    led_reg == (state_reg == ST_ACTIVE))
    else $error("indicator outside window");

  a_fail_bit: assert property ( // R1
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == ST_CLEAR && enabled && cause.module_fail) |=>
    summary_reg[0] && inc_reg)
    else $error("module failure not recorded");

  c_incoming: cover property (@(posedge mclk) disable iff (!reset_n)
    inc_reg);
  c_outgoing: cover property (@(posedge mclk) disable iff (!reset_n)
    out_reg);
  c_stamp_read: cover property (@(posedge mclk) disable iff (!reset_n)
    rd_en && rd_addr == imdr_pkg::OFS_TIMESTAMP && state_reg == ST_ACTIVE);

endmodule

/* imdr_coupler.sv */
`timescale 1ns/10ps
module imdr_coupler
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Record read port of the module
  output logic            rd_en,
  output logic [4:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  // Diagnostic event from the module
  input  wire logic       diag_incoming
);
  // ****************************************************************
  // Coupler fetching the record after each incoming event
  // ****************************************************************
  logic [7:0] rec [0:19];
  int         n_rec = 0;
  int         lag = 0;

  // The answer is taken one cycle late, so both read latencies work.
  task automatic read_byte(input logic [4:0] a, output logic [7:0] v);
    rd_en = 1'b1;
    rd_addr = a;
    @(posedge mclk);
    #1;
    rd_en = 1'b0;
    rd_addr = ~a;
    @(posedge mclk);
    #1;
    v = rd_data;
  endtask

  // A slow coupler is modelled by lag idle cycles before the fetch.
  initial
  begin
    rd_en = 1'b0;
    rd_addr = 5'h00;
    forever
    begin
      @(posedge mclk);
      if (diag_incoming === 1'b1 && reset_n === 1'b1)
      begin
        #1;
        repeat (lag)
        begin
          @(posedge mclk);
          #1;
        end
        for (int a = 0; a < 20; a++)
          read_byte(a[4:0], rec[a]);
        n_rec++;
      end
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  // ****************************************************************
  // Signals, model state and counters
  // ****************************************************************
  logic                     mclk;
  logic                     reset_n;
  imdr_pkg::imdr_cause_type cause;
  logic [3:0]               input_line;
  logic [3:0]               input_state;
  logic [7:0]               diag_irq_enable;
  logic                     rd_en;
  logic [4:0]               rd_addr;
  logic [7:0]               rd_data;
  logic                     diag_incoming;
  logic                     diag_outgoing;
  logic                     fault_indicator;
  logic [7:0]               d;
  logic [31:0]              seed = 32'h3ecc;
  logic [31:0]              tick;
  logic [7:0]               exp_rec [0:31];
  int                       cnt;
  int                       mismatches = 0;
  int                       n_checks = 0;
  int                       n_in = 0;
  int                       n_out = 0;

  imdr_diag_record dut_u
  (
    .mclk(mclk), .reset_n(reset_n), .cause(cause),
    .input_line(input_line), .diag_irq_enable(diag_irq_enable),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .diag_incoming(diag_incoming), .diag_outgoing(diag_outgoing),
    .fault_indicator(fault_indicator), .input_state(input_state)
  );

  imdr_coupler cpl_u
  (
    .mclk(mclk), .reset_n(reset_n), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .diag_incoming(diag_incoming)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Reference ticker: one count per 100 clocks, restarted by reset.
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cnt <= 0;
      tick <= 32'h0;
    end
    else if (cnt == 99)
    begin
      cnt <= 0;
      tick <= tick + 32'h1;
    end
    else
      cnt <= cnt + 1;
    if (diag_incoming === 1'b1)
      n_in++;
    if (diag_outgoing === 1'b1)
      n_out++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string w, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic model_clear();
    for (int a = 0; a < 32; a++)
      exp_rec[a] = 8'h00;
    exp_rec[1] = {3'b000, 1'b1, imdr_pkg::CLASS_DIGITAL};
    exp_rec[4] = {1'b0, imdr_pkg::KIND_DIGITAL_IN};
    exp_rec[5] = imdr_pkg::DIAG_BITS_VALUE;
    exp_rec[6] = imdr_pkg::CHANNEL_COUNT_VAL;
  endtask

  task automatic rd_all();
    for (int a = 0; a < 32; a++)
    begin
      cpl_u.read_byte(a[4:0], d);
      chk("record byte", exp_rec[a], d);
    end
  endtask

  // Raises a cause mid-tick, so the stamp never sits on a boundary.
  task automatic event_run(input logic [7:0] c, input int lag);
    int k;
    do
    begin
      @(posedge mclk);
      #1;
    end
    while (cnt != 50);
    cpl_u.lag = lag;
    k = cpl_u.n_rec;
    cause = c;
    input_line = 4'(xs());
    exp_rec[0] = {4'h0, |c[3:0], c[6], 1'b0, c[7]};
    exp_rec[3] = {1'b0, c[4], 2'b00, c[5], 3'b000};
    exp_rec[7] = {4'h0, c[3:0]};
    {exp_rec[19], exp_rec[18], exp_rec[17], exp_rec[16]} = tick;
    @(posedge mclk);
    #1;
    chk("incoming", 1, diag_incoming);
    chk("indicator on", 1, fault_indicator);
    @(posedge mclk);
    #1;
    chk("incoming pulse", 0, diag_incoming);
    for (int w = 0; w < 300 && cpl_u.n_rec == k; w++)
      @(posedge mclk);
    #1;
    chk("record fetched", k + 1, cpl_u.n_rec);
    for (int a = 0; a < 20; a++)
      chk("fetched byte", exp_rec[a], cpl_u.rec[a]);
    k = n_in;
    cause = c | 8'(xs());
    rd_all();
    chk("no new incoming", k, n_in);
    chk("indicator held", 1, fault_indicator);
    chk("input state", input_line, input_state);
    k = n_out;
    if (xs() & 32'h1)
      cause = '0;
    else
      diag_irq_enable = imdr_pkg::IRQ_ENABLE_OFF;
    @(posedge mclk);
    #1;
    chk("outgoing", 1, diag_outgoing);
    chk("indicator off", 0, fault_indicator);
    cause = '0;
    @(posedge mclk);
    #1;
    chk("one outgoing", k + 1, n_out);
    diag_irq_enable = imdr_pkg::IRQ_ENABLE_ON;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    mismatches++;
    $display("Watchdog expired before the sequence ended");
    results();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    reset_n = 1'b0;
    cause = '0;
    input_line = 4'h0;
    diag_irq_enable = imdr_pkg::IRQ_ENABLE_ON;
    repeat (16) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    chk("indicator reset", 0, fault_indicator);
    model_clear();
    rd_all();
    for (int i = 0; i < 12; i++)
      event_run((i < 8) ? (8'h01 << i) : (8'(xs()) | 8'h01), (i % 3) * 7);
    // Any enable value other than the documented one keeps events out.
    for (int i = 0; i < 4; i++)
    begin
      d = 8'(xs());
      diag_irq_enable = (d == imdr_pkg::IRQ_ENABLE_ON) ? 8'h00 : d;
      cause = 8'(xs()) | 8'h80;
      repeat (4) @(posedge mclk);
      #1;
      chk("disabled incoming", 12, n_in);
      chk("disabled indicator", 0, fault_indicator);
    end
    cause = '0;
    diag_irq_enable = imdr_pkg::IRQ_ENABLE_ON;
    @(posedge mclk);
    #1;
    cause = 8'h0a;
    @(posedge mclk);
    #1;
    reset_n = 1'b0;
    cause = '0;
    repeat (2) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    chk("indicator after reset", 0, fault_indicator);
    model_clear();
    rd_all();
    event_run(8'h21, 3);
    results();
  end
endmodule
